// File: design/fer_qualifier.sv
// Purpose: Qualify and count retired instructions with front-end problems
// Assumes: Pipeline inputs are synchronous to i_clock
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "fer_defines.svh"

module fer_qualifier
#(
	parameter int CNT_W = 32
)
(
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_arst_n,
	// Avalon-MM slave
	input  wire logic [5:0]            i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	input  wire logic [3:0]            i_avs_byteenable,
	output logic      [31:0]           o_avs_readdata,
	output logic                       o_avs_waitrequest,
	// Front-end and retirement
	input  wire fer_pkg::fer_fe_type   i_fe,
	input  wire logic [2:0]            i_bubble_slots,
	input  wire logic                  i_backend_stall,
	input  wire fer_pkg::fer_ret_type  i_ret,
	// Sampling outputs
	output logic                       o_sample,
	output logic [63:0]                o_rec_addr,
	output logic [63:0]                o_rec_status,
	output logic [63:0]                o_rec_rsvd,
	output logic [CNT_W-1:0]           o_count
);

	initial
	begin
		if (CNT_W < 1 || CNT_W > 32)
			$error("CNT_W must be 1 to 32");
	end

	fer_pkg::fer_state_type s_q;
	fer_pkg::fer_state_type s_d;
	logic [1:0]             rs_q;
	logic                   rst_n;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// ============================================================
	// Reset release
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rs_q <= 2'h0;
		else
			rs_q <= {rs_q[0], 1'b1};
	end
	assign rst_n = rs_q[1];

	// ============================================================
	// Next state
	logic [7:0]  sub;
	logic [11:0] len_thr;
	logic [2:0]  wid_thr;
	logic        evt_sel_ok;
	logic        cond;
	logic        bubble_cyc;
	logic        new_line;
	logic        fire;
	logic        acc;
	logic [31:0] rd;
	logic [31:0] mw;

	always_comb
	begin
		s_d = s_q;
		s_d.rst_sync = 2'h0;
		mw = 32'h0;
		sub = s_q.qual[`FER_SUB_MSB:`FER_SUB_LSB];
		len_thr = s_q.qual[`FER_LEN_MSB:`FER_LEN_LSB];
		wid_thr = s_q.qual[`FER_WID_MSB:`FER_WID_LSB];
		// Cross-thread bit masked out of the match
		evt_sel_ok = s_q.frontend_subevent_code[7:0] == `FER_EVT_CODE
			&& s_q.frontend_subevent_code[15:8] == `FER_EVT_UNIT_MASK;
		// Secondary misses never qualify for the cache and TLB sub-events
		new_line = !i_fe.secondary
			&& !(s_q.line_valid && s_q.last_line == i_fe.line_addr);
		unique case (sub)
			`FER_SUB_ANY_DSB:    cond = i_fe.any_decode_buffer_miss;
			`FER_SUB_DSB_STARVE: cond = i_fe.starve_starving_decode_buffer_miss;
			`FER_SUB_L1I:        cond = i_fe.instr_cache_true_miss && new_line;
			`FER_SUB_L2:         cond = i_fe.second_cache_true_miss && new_line;
			`FER_SUB_ITLB:       cond = i_fe.instr_tlb_true_miss && new_line;
			`FER_SUB_STLB:       cond = i_fe.second_level_tlb_true_miss && new_line;
			default:             cond = 1'b0;
		endcase
		if ((i_fe.instr_cache_true_miss || i_fe.second_cache_true_miss || i_fe.instr_tlb_true_miss || i_fe.second_level_tlb_true_miss)
			&& !i_fe.secondary)
		begin
			s_d.last_line = i_fe.line_addr;
			s_d.line_valid = 1'b1;
		end
		// Bubble run tracking
		bubble_cyc = !i_backend_stall && i_bubble_slots <= `FER_ALLOC_SLOTS
			&& i_bubble_slots >= wid_thr && i_bubble_slots != 3'h0;
		if (sub == `FER_SUB_BUBBLES)
		begin
			if (bubble_cyc)
			begin
				if (s_q.run != 12'hfff)
					s_d.run = s_q.run + 12'h1;
				if (s_q.run + 12'h1 >= len_thr)
					cond = 1'b1;
			end
			else if (!i_backend_stall)
				s_d.run = 12'h0;
		end
		// Pending held until the next retiring instruction
		if (cond)
			s_d.pend = 1'b1;
		fire = 1'b0;
		if (i_ret.valid && i_ret.last_uop && (s_q.pend || cond))
		begin
			fire = evt_sel_ok;
			s_d.pend = 1'b0;
			s_d.run = 12'h0;
		end
		s_d.sample = fire && s_q.precise_sampling_en;
		if (fire)
			s_d.count = s_q.count + 32'h1;
		if (fire && s_q.precise_sampling_en && s_q.dla_en && i_ret.is_mem)
		begin
			s_d.rec_addr = i_ret.lin_addr;
			s_d.rec_status = 64'h0;
			s_d.rec_status[`FER_STORE_HIT_BIT] = i_ret.store_event
				&& i_ret.l1_store_hit;
			s_d.rec_rsvd = 64'h0;
			s_d.rec_valid = 1'b1;
		end
		// Bus slave: one-cycle wait then answer
		acc = (i_avs_read || i_avs_write) && !s_q.rsp;
		s_d.rsp = acc;
		rd = 32'h0;
		unique case (i_avs_address)
			`FER_ADDR_QUAL_LO:     rd = {9'h0, s_q.qual};
			`FER_ADDR_QUAL_HI:     rd = 32'h0;
			`FER_ADDR_FRONTEND_SUBEVENT_CODE:      rd = {8'h0, s_q.frontend_subevent_code};
			`FER_ADDR_COUNT:       rd = s_q.count;
			`FER_ADDR_CTRL:        rd = {30'h0, s_q.dla_en, s_q.precise_sampling_en};
			`FER_ADDR_REC_ADDR_LO: rd = s_q.rec_addr[31:0];
			`FER_ADDR_REC_ADDR_HI: rd = s_q.rec_addr[63:32];
			`FER_ADDR_REC_STATUS:  rd = s_q.rec_status[31:0];
			`FER_ADDR_REC_RSVD:    rd = s_q.rec_rsvd[31:0];
			`FER_ADDR_REC_VALID:   rd = {31'h0, s_q.rec_valid};
			default:               rd = 32'h0;
		endcase
		if (acc && i_avs_read)
		begin
			s_d.rdata = rd;
			if (i_avs_address == `FER_ADDR_REC_VALID)
				s_d.rec_valid = 1'b0;
		end
		if (acc && i_avs_write)
		begin
			unique case (i_avs_address)
				`FER_ADDR_QUAL_LO:
				begin
					mw = merge({9'h0, s_q.qual}, i_avs_writedata,
						i_avs_byteenable) & `FER_QUAL_MASK;
					s_d.qual = mw[22:0];
					s_d.run = 12'h0;
					s_d.pend = 1'b0;
				end
				`FER_ADDR_FRONTEND_SUBEVENT_CODE:
				begin
					mw = merge({8'h0, s_q.frontend_subevent_code}, i_avs_writedata,
						i_avs_byteenable);
					s_d.frontend_subevent_code = mw[23:0];
				end
				`FER_ADDR_COUNT:
					s_d.count = merge(s_q.count, i_avs_writedata, i_avs_byteenable);
				`FER_ADDR_CTRL:
					if (i_avs_byteenable[0])
					begin
						s_d.precise_sampling_en = i_avs_writedata[0];
						s_d.dla_en = i_avs_writedata[1];
					end
				default:
					s_d.rsp = acc;
			endcase
		end
		if (fire && acc && i_avs_write && i_avs_address == `FER_ADDR_COUNT)
			s_d.count = s_q.count + 32'h1;
	end

	// ============================================================
	// State register
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '0;
		else if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ============================================================
	// Outputs
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_q.rsp;
	assign o_avs_readdata    = s_q.rdata;
	assign o_sample          = s_q.sample;
	assign o_rec_addr        = s_q.rec_addr;
	assign o_rec_status      = s_q.rec_status;
	assign o_rec_rsvd        = s_q.rec_rsvd;
	assign o_count           = s_q.count[CNT_W-1:0];

endmodule

// File: inc/fer_defines.svh
// Purpose: Constants for the front-end retired event qualifier
// Assumes: 100 MHz core clock, Avalon-MM word addressing in bytes
// Notes:   Included by bare name
`ifndef FER_DEFINES_SVH
`define FER_DEFINES_SVH

// ============================================================
// Register map (byte addresses)
`define FER_ADDR_QUAL_LO      6'h00
`define FER_ADDR_QUAL_HI      6'h04
`define FER_ADDR_FRONTEND_SUBEVENT_CODE       6'h08
`define FER_ADDR_COUNT        6'h0c
`define FER_ADDR_CTRL         6'h10
`define FER_ADDR_REC_ADDR_LO  6'h14
`define FER_ADDR_REC_ADDR_HI  6'h18
`define FER_ADDR_REC_STATUS   6'h1c
`define FER_ADDR_REC_RSVD     6'h20
`define FER_ADDR_REC_VALID    6'h24

// ============================================================
// Qualifier fields
`define FER_SUB_LSB           0
`define FER_SUB_MSB           7
`define FER_LEN_LSB           8
`define FER_LEN_MSB           19
`define FER_WID_LSB           20
`define FER_WID_MSB           22
`define FER_QUAL_MASK         32'h007f_ffff

// ============================================================
// Sub-event codes
`define FER_SUB_ANY_DSB       8'h01
`define FER_SUB_DSB_STARVE    8'h11
`define FER_SUB_L1I           8'h12
`define FER_SUB_L2            8'h13
`define FER_SUB_ITLB          8'h14
`define FER_SUB_STLB          8'h15
`define FER_SUB_BUBBLES       8'h06

// ============================================================
// Counter event select fields
`define FER_EVT_CODE          8'hc6
`define FER_EVT_UNIT_MASK         8'h01
`define FER_FRONTEND_SUBEVENT_CODE_MASK       32'h00ff_ffff
`define FER_CROSS_THREAD_COUNT_FLAG_BIT     21

// ============================================================
// Sampling record offsets and fields
`define FER_REC_OFS_ADDR      8'h98
`define FER_REC_OFS_STATUS    8'ha0
`define FER_REC_OFS_RSVD      8'ha8
`define FER_STORE_HIT_BIT     0
`define FER_ALLOC_SLOTS       3'h4

`endif

// File: inc/fer_pkg.sv
// Purpose: Types for the front-end retired event qualifier
// Assumes: fer_defines.svh holds the numbers
// Notes:   None
package fer_pkg;

	// Front-end condition strobes from the pipeline
	typedef struct packed {
		logic        any_decode_buffer_miss;
		logic        starve_starving_decode_buffer_miss;
		logic        instr_cache_true_miss;
		logic        second_cache_true_miss;
		logic        instr_tlb_true_miss;
		logic        second_level_tlb_true_miss;
		logic        secondary;
		logic [47:0] line_addr;
	} fer_fe_type;

	// Retirement slot
	typedef struct packed {
		logic        valid;
		logic        fused;
		logic        last_uop;
		logic        store_event;
		logic        l1_store_hit;
		logic        is_mem;
		logic [63:0] lin_addr;
	} fer_ret_type;

	// Whole state
	typedef struct packed {
		logic [1:0]  rst_sync;
		logic [22:0] qual;
		logic [23:0] frontend_subevent_code;
		logic        precise_sampling_en;
		logic        dla_en;
		logic [31:0] count;
		logic        pend;
		logic [47:0] last_line;
		logic        line_valid;
		logic [11:0] run;
		logic        bubble_hit;
		logic [63:0] rec_addr;
		logic [63:0] rec_status;
		logic [63:0] rec_rsvd;
		logic        rec_valid;
		logic        rsp;
		logic [31:0] rdata;
		logic        sample;
	} fer_state_type;

endpackage

// File: sim/fer_qualifier_asserts.sv
// Purpose: Port checks for fer_qualifier
// Assumes: Bound from the bench top
// Notes:   None
`timescale 1ns/10ps
module fer_qualifier_asserts
#(
	parameter int CNT_W = 32
)
(
	// Clock, reset, bus
	input wire logic                 i_clock,
	input wire logic                 i_arst_n,
	input wire logic                 i_avs_read,
	input wire logic                 i_avs_write,
	input wire logic                 o_avs_waitrequest,
	// Retire and results
	input wire fer_pkg::fer_ret_type i_ret,
	input wire logic                 o_sample,
	input wire logic [63:0]          o_rec_addr,
	input wire logic [63:0]          o_rec_status,
	input wire logic [63:0]          o_rec_rsvd,
	input wire logic [CNT_W-1:0]     o_count
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	property p_rsvd; o_rec_rsvd == 64'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved entry nonzero");
	property p_stat; o_rec_status[63:1] == 63'h0; endproperty
	a_stat: assert property (p_stat) else $error("status upper bits set");
	property p_ret; $changed(o_count) |-> $past(i_ret.valid && i_ret.last_uop); endproperty
	a_ret: assert property (p_ret) else $error("count without retire");
	property p_step; $changed(o_count) |-> o_count == $past(o_count) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("count step not one");
	property p_smp; o_sample |-> $changed(o_count); endproperty
	a_smp: assert property (p_smp) else $error("sample without count");
	property p_addr;
		$changed(o_rec_addr) |-> $past(i_ret.valid && i_ret.is_mem)
			&& o_rec_addr == $past(i_ret.lin_addr);
	endproperty
	a_addr: assert property (p_addr) else $error("record address wrong");
	property p_hit;
		$changed(o_rec_addr) && $past(i_ret.store_event)
			|-> o_rec_status[0] == $past(i_ret.l1_store_hit);
	endproperty
	a_hit: assert property (p_hit) else $error("store hit bit wrong");
	property p_wt; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
	a_wt: assert property (p_wt) else $error("bus answer late");
endmodule

// File: sim/fer_fe_model.sv
// Purpose: Front end and retirement stand-in
// Assumes: Driven by task calls from the bench
// Notes:   Idle address lines toggle so stale values never look valid
`timescale 1ns/10ps
module fer_fe_model
(
	// Clock
	input  wire logic            i_clock,
	// Pipeline side
	output fer_pkg::fer_fe_type  o_fe,
	output fer_pkg::fer_ret_type o_ret,
	output logic [2:0]           o_slots,
	output logic                 o_stall
);
	initial
	begin
		o_fe = '0;
		o_ret = '0;
		o_slots = 3'h0;
		o_stall = 1'b0;
	end
	task automatic idle();
		@(posedge i_clock);
		o_fe <= {7'h0, ~o_fe.line_addr};
		o_ret <= {6'h0, ~o_ret.lin_addr};
		o_slots <= 3'h0;
		o_stall <= 1'b0;
	endtask
	task automatic miss(input int k, input logic sec, input logic [47:0] line);
		logic [5:0] v;
		v = 6'h20 >> k;
		v[5] = v[5] | (k == 1);
		@(posedge i_clock);
		o_fe <= {v, sec, line};
		idle();
	endtask
	task automatic retire(input logic fu, input logic last, input logic [63:0] la, input logic hit);
		@(posedge i_clock);
		o_ret <= {1'b1, fu, last, 1'b1, hit, 1'b1, la};
		idle();
	endtask
	task automatic bubble(input logic [2:0] s, input logic st, input int n);
		repeat (n)
		begin
			@(posedge i_clock);
			o_slots <= s;
			o_stall <= st;
		end
		idle();
	endtask
endmodule

// File: sim/fer_qualifier_tb_top.sv
// Purpose: Self-checking bench for fer_qualifier
// Assumes: Expected count kept in integers
// Notes:   Checker bound at the foot
`timescale 1ns/10ps
`include "fer_defines.svh"
module fer_qualifier_tb_top;
	logic        i_clock = 1'b0;
	logic        i_arst_n = 1'b0;
	logic [5:0]  adr = 6'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdq, rdat, cnt, d;
	logic        wt, smp, st, hit;
	logic [63:0] ra, rs, rr, la;
	logic [2:0]  sl;
	logic [47:0] line = 48'h100;
	logic [7:0]  codes [6] = '{8'h01, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
	fer_pkg::fer_fe_type  fe;
	fer_pkg::fer_ret_type ret;
	int error_cnt = 0;
	int compares = 0;
	int seed = 29;
	int exp_cnt = 0;
	always #5 i_clock = ~i_clock;
	fer_qualifier u_fer_qualifier
	(
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdq), .o_avs_waitrequest(wt), .i_fe(fe), .i_bubble_slots(sl),
		.i_backend_stall(st), .i_ret(ret), .o_sample(smp), .o_rec_addr(ra),
		.o_rec_status(rs), .o_rec_rsvd(rr), .o_count(cnt)
	);
	fer_fe_model u_fer_fe_model
	(
		.i_clock(i_clock), .o_fe(fe), .o_ret(ret), .o_slots(sl), .o_stall(st)
	);
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] dd);
		int n;
		n = 0;
		@(posedge i_clock);
		adr <= a;
		wd <= dd;
		wr <= w;
		rd <= !w;
		do
		begin
			@(negedge i_clock);
			n++;
		end
		while (wt !== 1'b0 && n < 20);
		@(posedge i_clock);
		rdat = rdq;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20)
		begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	task automatic fm(input int k, input logic sec);
		line = line + 48'h40;
		u_fer_fe_model.miss(k, sec, line);
	endtask
	task automatic rc(input logic fu, input logic last, input int inc);
		la = {$random(seed), $random(seed)};
		hit = $random(seed);
		u_fer_fe_model.retire(fu, last, la, hit);
		@(negedge i_clock);
		exp_cnt += inc;
		chk(cnt, exp_cnt);
		chk(smp, inc);
		if (inc)
		begin
			chk(ra, la);
			chk(rs, hit);
			chk(rr, 64'h0);
		end
	endtask
	initial
	begin
		repeat (16) @(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		bus(1, `FER_ADDR_FRONTEND_SUBEVENT_CODE, 32'h0020_01c6);
		bus(1, `FER_ADDR_CTRL, 32'h3);
		d = $random(seed);
		bus(1, `FER_ADDR_QUAL_LO, d);
		bus(0, `FER_ADDR_QUAL_LO, 0);
		chk(rdat, d & `FER_QUAL_MASK);
		bus(0, `FER_ADDR_QUAL_HI, 0);
		chk(rdat, 0);
		bus(0, 6'h3c, 0);
		chk(rdat, 0);
		for (int k = 0; k < 6; k++)
		begin
			bus(1, `FER_ADDR_QUAL_LO, {24'h0, codes[k]});
			for (int j = 0; j < 6; j++)
			begin
				fm(j, 1'b0);
				rc(0, 1, (j == k) || (k == 0 && j == 1));
			end
		end
		fm(5, 1'b1);
		rc(0, 1, 0);
		fm(5, 1'b0);
		rc(0, 1, 1);
		u_fer_fe_model.miss(5, 1'b0, line);
		rc(0, 1, 0);
		fm(5, 1'b0);
		fm(5, 1'b0);
		rc(1, 1, 1);
		fm(5, 1'b0);
		rc(0, 0, 0);
		rc(0, 1, 1);
		fm(5, 1'b0);
		repeat (8) @(posedge i_clock);
		chk(cnt, exp_cnt);
		rc(0, 1, 1);
		bus(1, `FER_ADDR_FRONTEND_SUBEVENT_CODE, 32'h0000_01c5);
		fm(5, 1'b0);
		rc(0, 1, 0);
		bus(1, `FER_ADDR_FRONTEND_SUBEVENT_CODE, 32'h0000_01c6);
		bus(1, `FER_ADDR_QUAL_LO, 32'h0020_0306);
		u_fer_fe_model.bubble(3'h2, 1'b0, 2);
		rc(0, 1, 0);
		u_fer_fe_model.bubble(3'h4, 1'b1, 5);
		rc(0, 1, 0);
		u_fer_fe_model.bubble(3'h1, 1'b0, 5);
		rc(0, 1, 0);
		u_fer_fe_model.bubble(3'h2, 1'b0, 3);
		rc(0, 1, 1);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		chk(cnt, 0);
		tally_and_finish();
	end
endmodule
bind fer_qualifier fer_qualifier_asserts #(.CNT_W(CNT_W)) u_fer_qualifier_asserts
(
	.i_clock, .i_arst_n, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_ret,
	.o_sample, .o_rec_addr, .o_rec_status, .o_rec_rsvd, .o_count
);
